// >>> hdl/uoe_pkg.sv
// Constants and types shared by the OUT endpoint descriptor block.
// Assumes a 32-bit classic Wishbone slave and one system clock.
package uoe_pkg;

    // =====================================================================
    // Buffer address format
    localparam int unsigned ADDR_W   = 11;
    localparam int unsigned BASE_W   = 8;
    localparam int unsigned BASE_PAD = 3;
    localparam int unsigned CNT_W    = 7;
    localparam logic [6:0]  MAX_BYTES = 7'h40;

    // =====================================================================
    // Descriptor entry indices (byte address is four times the index)
    localparam logic [2:0] OFS_CFG   = 3'h0;
    localparam logic [2:0] OFS_XBASE = 3'h1;
    localparam logic [2:0] OFS_XCNT  = 3'h2;
    localparam logic [2:0] OFS_YBASE = 3'h5;
    localparam logic [2:0] OFS_YCNT  = 3'h6;
    localparam logic [2:0] OFS_SIZE  = 3'h7;
    localparam logic [5:0] IDX_IRQ_STS = 6'h20;
    localparam logic [5:0] IDX_IRQ_MSK = 6'h21;

    // =====================================================================
    // Field positions and masks
    localparam int unsigned CFG_EN   = 7;
    localparam int unsigned CFG_ISO  = 6;
    localparam int unsigned CFG_TOG  = 5;
    localparam int unsigned CFG_DOUBLE_BUFFER_ENABLE = 4;
    localparam int unsigned CFG_STALL = 3;
    localparam int unsigned CFG_IE   = 2;
    localparam int unsigned CNT_NAK  = 7;
    localparam logic [7:0]  CFG_WR_MASK  = 8'hFC;
    localparam logic [7:0]  SIZE_WR_MASK = 8'h7F;
    localparam logic [7:0]  REG_RESET    = 8'h00;

    // =====================================================================
    // Handshake codes and receive states
    typedef enum logic [1:0] {
        UOE_HS_ACK   = 2'b00,
        UOE_HS_NAK   = 2'b01,
        UOE_HS_STALL = 2'b10
    } uoe_hs_t;

    typedef enum logic [1:0] {
        UOE_ST_IDLE = 2'b00,
        UOE_ST_RECV = 2'b01,
        UOE_ST_DROP = 2'b10
    } uoe_st_t;

endpackage

// >>> hdl/uoe_wr_if.sv
// Link between the descriptor logic and its buffer writer.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface uoe_wr_if;
    logic        start;
    logic [7:0]  base;
    logic        bvld;
    logic [7:0]  bdat;
    logic        ram_we;
    logic [10:0] ram_addr;
    logic [7:0]  ram_wdata;
    logic [6:0]  count;
    logic        ovf;
    modport ctl (output start, base, bvld, bdat,
                 input ram_we, ram_addr, ram_wdata, count, ovf);
    modport wr  (input start, base, bvld, bdat,
                 output ram_we, ram_addr, ram_wdata, count, ovf);
endinterface

// >>> hdl/uoe_buf_writer.sv
// Writes the bytes of one OUT packet into buffer RAM from a base address.
// Assumes start precedes the first byte by at least one cycle.
`timescale 1ns/1ps
module uoe_buf_writer
    import uoe_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control side
    uoe_wr_if.wr     wr
);

    logic [ADDR_W-1:0] ptr_ff;
    logic [CNT_W-1:0]  cnt_ff;
    logic              ovf_ff;
    logic              we_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [7:0]        data_ff;

    // =====================================================================
    // Full address from the stored upper bits
    function automatic logic [ADDR_W-1:0] full_addr(input logic [BASE_W-1:0] b);
        full_addr = {b, {BASE_PAD{1'b0}}};
    endfunction

    // Pointer and count; every packet starts at the base, base untouched
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_ff <= '0;
            cnt_ff <= '0;
            ovf_ff <= 1'b0;
        end else if (wr.start) begin
            ptr_ff <= full_addr(wr.base);
            cnt_ff <= '0;
            ovf_ff <= 1'b0;
        end else if (wr.bvld) begin
            // Bytes past the limit are dropped, not written over neighbours
            if (cnt_ff < MAX_BYTES) begin
                ptr_ff <= ptr_ff + 11'h001;
                cnt_ff <= cnt_ff + 7'h01;
            end else begin
                ovf_ff <= 1'b1;
            end
        end
    end

    // RAM write port, registered
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            we_ff   <= 1'b0;
            addr_ff <= '0;
            data_ff <= '0;
        end else begin
            we_ff   <= wr.bvld && !wr.start && (cnt_ff < MAX_BYTES);
            addr_ff <= ptr_ff;
            data_ff <= wr.bdat;
        end
    end

    assign wr.ram_we    = we_ff;
    assign wr.ram_addr  = addr_ff;
    assign wr.ram_wdata = data_ff;
    assign wr.count     = cnt_ff;
    assign wr.ovf       = ovf_ff;

endmodule // uoe_buf_writer

// >>> hdl/usb_out_endpoint_descriptor.sv
// Descriptors of OUT endpoints 1 to 3 and the logic that acts on them.
// Assumes a packet engine on the same clock and a 32-bit Wishbone master.
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
module usb_out_endpoint_descriptor
    import uoe_pkg::*;
#(
    parameter int unsigned EP_COUNT = 3
) (
    // Clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RSTN,
    // Wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output      logic [31:0] WB_DAT_O,
    output      logic        WB_ACK_O,
    // OUT packet from the packet engine
    input  wire logic        OUT_START,
    input  wire logic [1:0]  OUT_EP,
    input  wire logic        OUT_PID_DATA1,
    input  wire logic        OUT_BYTE_VLD,
    input  wire logic [7:0]  OUT_BYTE,
    input  wire logic        OUT_DONE,
    input  wire logic        OUT_ABORT,
    // Handshake back to the packet engine
    output      logic        HS_VLD,
    output      logic [1:0]  HS_CODE,
    // Buffer RAM write port
    output      logic        RAM_WE,
    output      logic [10:0] RAM_ADDR,
    output      logic [7:0]  RAM_WDATA,
    // Interrupt
    output      logic        IRQ
);

    // =====================================================================
    // Elaboration checks
    // The endpoint field is two bits and endpoint 0 is not served here
    if (EP_COUNT < 1 || EP_COUNT > 3) begin : g_bad_ep_count
        $error("EP_COUNT must be 1 to 3");
    end
    // The stored base plus its zero padding must fill the buffer address
    if (BASE_W + BASE_PAD != ADDR_W) begin : g_bad_addr_w
        $error("base width and padding do not match the buffer address");
    end

    // =====================================================================
    // Descriptor storage
    logic [7:0] cfg_ff   [EP_COUNT];
    logic [7:0] xbase_ff [EP_COUNT];
    logic [7:0] xcnt_ff  [EP_COUNT];
    logic [7:0] ybase_ff [EP_COUNT];
    logic [7:0] ycnt_ff  [EP_COUNT];
    logic [7:0] size_ff  [EP_COUNT];

    logic [EP_COUNT-1:0] irq_sts_ff;
    logic [EP_COUNT-1:0] irq_msk_ff;

    // Bus slave state
    logic        ack_ff;
    logic [31:0] rdat_ff;
    logic        bus_req;
    logic        bus_wr;
    logic [5:0]  widx;
    logic [2:0]  wep;

    // Receive state
    uoe_st_t     st_ff;
    uoe_st_t     nxt_st;
    logic [1:0]  cur_ep_ff;
    logic        cur_y_ff;
    uoe_hs_t     pend_ff;
    logic        hs_vld_ff;
    uoe_hs_t     hs_code_ff;
    logic        commit;
    logic        start_ok;
    logic [1:0]  req_idx;
    logic        req_valid;
    logic [7:0]  req_cfg;
    logic        req_y;
    logic [7:0]  req_cnt;

    uoe_wr_if wif ();

    // =====================================================================
    // Helper functions
    // Buffer chosen for a packet from the configuration byte
    function automatic logic pick_y(input logic [7:0] cfg);
        pick_y = cfg[CFG_DOUBLE_BUFFER_ENABLE] & cfg[CFG_TOG];
    endfunction

    // Endpoint index of a register word, valid flag in the top bit
    function automatic logic [2:0] ep_of(input logic [5:0] idx);
        logic [2:0] n;
        n = {1'b0, idx[4:3]};
        if (idx[5] || n == 3'h0 || n > EP_COUNT[2:0]) begin
            ep_of = 3'h0;
        end else begin
            ep_of = {1'b1, 2'(n - 3'h1)};
        end
    endfunction

    // =====================================================================
    // Wishbone decode; answer one cycle after the request is seen
    assign bus_req = WB_CYC_I && WB_STB_I && !ack_ff;
    assign bus_wr  = bus_req && WB_WE_I && WB_SEL_I[0];
    assign widx    = WB_ADR_I[7:2];
    // Endpoint slot of the word, decoded once for reads and writes alike
    assign wep     = ep_of(widx);

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= bus_req;
        end
    end

    // Read data, captured with the request so it stands with ack
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            rdat_ff <= '0;
        end else if (bus_req) begin
            rdat_ff <= '0;
            if (widx == IDX_IRQ_STS) begin
                rdat_ff[EP_COUNT-1:0] <= irq_sts_ff;
            end else if (widx == IDX_IRQ_MSK) begin
                rdat_ff[EP_COUNT-1:0] <= irq_msk_ff;
            end else if (wep[2]) begin
                unique case (widx[2:0])
                    OFS_CFG:   rdat_ff[7:0] <= cfg_ff[wep[1:0]];
                    OFS_XBASE: rdat_ff[7:0] <= xbase_ff[wep[1:0]];
                    OFS_XCNT:  rdat_ff[7:0] <= xcnt_ff[wep[1:0]];
                    OFS_YBASE: rdat_ff[7:0] <= ybase_ff[wep[1:0]];
                    OFS_YCNT:  rdat_ff[7:0] <= ycnt_ff[wep[1:0]];
                    OFS_SIZE:  rdat_ff[7:0] <= size_ff[wep[1:0]];
                    default:   rdat_ff[7:0] <= 8'h00;          // Spare entries
                endcase
            end
        end
    end

    assign WB_ACK_O = ack_ff;
    assign WB_DAT_O = rdat_ff;

    // =====================================================================
    // Request lookup for an incoming OUT packet
    assign req_valid = (OUT_EP != 2'h0) && ({1'b0, OUT_EP} <= EP_COUNT[2:0]);
    assign req_idx   = 2'(OUT_EP - 2'h1);
    assign req_cfg   = req_valid ? cfg_ff[req_idx] : REG_RESET;
    assign req_y     = pick_y(req_cfg);
    // Count and NAK flag of the buffer this packet would fill
    assign req_cnt   = !req_valid ? REG_RESET :
                       req_y ? ycnt_ff[req_idx] : xcnt_ff[req_idx];
    // Only an enabled endpoint is looked at at all
    assign start_ok  = (st_ff == UOE_ST_IDLE) && OUT_START
                       && req_valid && req_cfg[CFG_EN];

    // Good packet with fresh data lands in the buffer
    assign commit = (st_ff == UOE_ST_RECV) && OUT_DONE && !wif.ovf;

    // =====================================================================
    // Descriptor registers; hardware updates win over a same-cycle write
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            for (int i = 0; i < EP_COUNT; i++) begin
                cfg_ff[i]   <= REG_RESET;
                xbase_ff[i] <= REG_RESET;
                xcnt_ff[i]  <= REG_RESET;
                ybase_ff[i] <= REG_RESET;
                ycnt_ff[i]  <= REG_RESET;
                size_ff[i]  <= REG_RESET;
            end
        end else begin
            // Firmware writes; only byte lane 0 carries a register
            if (bus_wr && wep[2]) begin
                unique case (widx[2:0])
                    OFS_CFG:   cfg_ff[wep[1:0]]   <= WB_DAT_I[7:0] & CFG_WR_MASK;
                    OFS_XBASE: xbase_ff[wep[1:0]] <= WB_DAT_I[7:0];
                    OFS_XCNT:  xcnt_ff[wep[1:0]]  <= WB_DAT_I[7:0];
                    OFS_YBASE: ybase_ff[wep[1:0]] <= WB_DAT_I[7:0];
                    OFS_YCNT:  ycnt_ff[wep[1:0]]  <= WB_DAT_I[7:0];
                    OFS_SIZE:  size_ff[wep[1:0]]  <= WB_DAT_I[7:0] & SIZE_WR_MASK;
                    default:   ;                               // Spare entries
                endcase
            end
            // Received packet: count, buffer full, toggle advances
            if (commit) begin
                if (cur_y_ff) begin
                    ycnt_ff[cur_ep_ff] <= {1'b1, wif.count};
                end else begin
                    xcnt_ff[cur_ep_ff] <= {1'b1, wif.count};
                end
                cfg_ff[cur_ep_ff][CFG_TOG] <= ~cfg_ff[cur_ep_ff][CFG_TOG];
            end
        end
    end

    // =====================================================================
    // Receive sequencer
    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            UOE_ST_IDLE: begin
                if (start_ok) begin
                    // Stall or a full buffer: data is discarded
                    if (req_cfg[CFG_STALL] || req_cnt[CNT_NAK]) begin
                        nxt_st = UOE_ST_DROP;
                    end else if (OUT_PID_DATA1 != req_cfg[CFG_TOG]) begin
                        // Host missed our last ACK; the data is already held
                        nxt_st = UOE_ST_DROP;
                    end else begin
                        nxt_st = UOE_ST_RECV;
                    end
                end
            end
            UOE_ST_RECV, UOE_ST_DROP: begin
                if (OUT_DONE || OUT_ABORT) begin
                    nxt_st = UOE_ST_IDLE;
                end
            end
            default: nxt_st = UOE_ST_IDLE;
        endcase
    end

    // Sequencer state register
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            st_ff <= UOE_ST_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Packet context latched at the start
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            cur_ep_ff <= 2'h0;
            cur_y_ff  <= 1'b0;
            pend_ff   <= UOE_HS_ACK;
        end else if (start_ok) begin
            cur_ep_ff <= req_idx;
            cur_y_ff  <= req_y;
            if (req_cfg[CFG_STALL]) begin
                pend_ff <= UOE_HS_STALL;
            end else if (req_cnt[CNT_NAK]) begin
                pend_ff <= UOE_HS_NAK;
            end else begin
                // Repeated packet after a lost ACK: acknowledge again
                pend_ff <= UOE_HS_ACK;
            end
        end
    end

    // Handshake pulse at the end of a good or dropped packet; aborts get none
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            hs_vld_ff  <= 1'b0;
            hs_code_ff <= UOE_HS_ACK;
        end else begin
            hs_vld_ff <= 1'b0;
            // An overflowed packet gets no handshake, so the host retries it
            if (st_ff == UOE_ST_DROP && OUT_DONE && !OUT_ABORT) begin
                hs_vld_ff  <= 1'b1;
                hs_code_ff <= pend_ff;
            end else if (commit && !OUT_ABORT) begin
                hs_vld_ff  <= 1'b1;
                hs_code_ff <= UOE_HS_ACK;
            end
        end
    end

    assign HS_VLD  = hs_vld_ff;
    assign HS_CODE = hs_code_ff;

    // =====================================================================
    // Buffer writer: base picked by the buffer choice
    assign wif.start = start_ok;
    assign wif.base  = req_y ? ybase_ff[req_idx] : xbase_ff[req_idx];
    assign wif.bvld  = (st_ff == UOE_ST_RECV) && OUT_BYTE_VLD;
    assign wif.bdat  = OUT_BYTE;

    uoe_buf_writer u_wr (
        .clk   (CLK_SYS),
        .rst_n (RSTN),
        .wr    (wif.wr)
    );

    // Buffer RAM port comes straight from the writer's flops
    assign RAM_WE    = wif.ram_we;
    assign RAM_ADDR  = wif.ram_addr;
    assign RAM_WDATA = wif.ram_wdata;

    // =====================================================================
    // Interrupt status and mask; a new event beats a same-cycle clear
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            irq_sts_ff <= '0;
            irq_msk_ff <= '0;
        end else begin
            // Mask is plain firmware state, never touched by hardware
            if (bus_wr && widx == IDX_IRQ_MSK) begin
                irq_msk_ff <= WB_DAT_I[EP_COUNT-1:0];
            end
            for (int i = 0; i < EP_COUNT; i++) begin
                if (commit && cur_ep_ff == 2'(i) && cfg_ff[i][CFG_IE]) begin
                    irq_sts_ff[i] <= 1'b1;
                end else if (bus_wr && widx == IDX_IRQ_STS && WB_DAT_I[i]) begin
                    irq_sts_ff[i] <= 1'b0;
                end
            end
        end
    end

    // Level output while any unmasked event is pending
    assign IRQ = |(irq_sts_ff & irq_msk_ff);

endmodule // usb_out_endpoint_descriptor

// >>> dv/uoe_asserts.sv
// Port checker of the OUT endpoint descriptor block.
// Assumes it is bound onto the top module; one clock domain.
`timescale 1ns/1ps
module uoe_asserts (
    // Clock and reset
    input wire logic        CLK_SYS,
    input wire logic        RSTN,
    // Register bus
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    // Packet side
    input wire logic        OUT_BYTE_VLD,
    input wire logic [7:0]  OUT_BYTE,
    input wire logic        OUT_DONE,
    input wire logic        OUT_ABORT,
    input wire logic        HS_VLD,
    input wire logic [1:0]  HS_CODE,
    input wire logic        RAM_WE,
    input wire logic [10:0] RAM_ADDR,
    input wire logic [7:0]  RAM_WDATA
);
    // =====================================================================
    // One domain, so clock and reset are given once
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);

    // =====================================================================
    // Buffer writes: aligned start, consecutive bytes, data from the link
    a_ram_first_aligned: assert property (RAM_WE && !$past(RAM_WE) |-> RAM_ADDR[2:0] == 3'h0)
        else $error("first buffer write not on an 8-byte boundary");
    a_ram_addr_step: assert property (RAM_WE && $past(RAM_WE) |->
        RAM_ADDR == $past(RAM_ADDR) + 11'h1)
        else $error("buffer address did not step by one");
    a_ram_data_byte: assert property (RAM_WE |->
        $past(OUT_BYTE_VLD) && RAM_WDATA == $past(OUT_BYTE))
        else $error("buffer write without a matching byte");

    // =====================================================================
    // Handshake follows a good end only, one cycle long, legal code
    a_hs_after_done: assert property (HS_VLD |-> $past(OUT_DONE))
        else $error("handshake without a packet end");
    a_abort_silent: assert property (OUT_ABORT |=> !HS_VLD [*2])
        else $error("handshake after an aborted packet");
    a_hs_pulse_code: assert property (HS_VLD |-> HS_CODE != 2'b11 ##1 !HS_VLD)
        else $error("handshake code or length wrong");

    // =====================================================================
    // Bus answers in the next cycle, one cycle long, upper bits zero
    a_ack_next_cycle: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("bus request not answered in one cycle");
    a_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("bus ack longer than one cycle");
    a_rdata_upper_zero: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
        else $error("read data upper bits not zero");

    // Main outcomes seen at least once
    c_hs_ack: cover property (HS_VLD && HS_CODE == 2'b00);
    c_hs_nak: cover property (HS_VLD && HS_CODE == 2'b01);
    c_hs_stall: cover property (HS_VLD && HS_CODE == 2'b10);
endmodule // uoe_asserts

bind usb_out_endpoint_descriptor uoe_asserts uoe_asserts_inst (
    .CLK_SYS(CLK_SYS), .RSTN(RSTN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .OUT_BYTE_VLD(OUT_BYTE_VLD),
    .OUT_BYTE(OUT_BYTE), .OUT_DONE(OUT_DONE), .OUT_ABORT(OUT_ABORT), .HS_VLD(HS_VLD),
    .HS_CODE(HS_CODE), .RAM_WE(RAM_WE), .RAM_ADDR(RAM_ADDR), .RAM_WDATA(RAM_WDATA)
);

// >>> dv/uoe_host_model.sv
// Behavioural USB host side: hands whole OUT packets to the block.
// Assumes one caller at a time, on the same clock as the block.
`timescale 1ns/1ps
module uoe_host_model (
    // Clock
    input wire logic clk,
    // Packet stream
    output logic       start,
    output logic [1:0] ep,
    output logic       pid,
    output logic       vld,
    output logic [7:0] bt,
    output logic       done,
    output logic       abort
);
    // =====================================================================
    // Quiet link at time zero
    initial begin
        {start, ep, pid, vld, done, abort} = 7'h00;
        bt = 8'h00;
    end

    // One packet; the byte bus shows the inverse of its last value when idle
    task automatic send(input logic [1:0] e, input logic p, input int n, input logic ab);
        int i;
        @(posedge clk);
        start <= 1'b1;
        ep    <= e;
        pid   <= p;
        for (i = 0; i < n && i < 64; i++) begin
            @(posedge clk);
            start <= 1'b0;
            vld   <= 1'b1;
            bt    <= 8'(i) ^ 8'h5A;
        end
        @(posedge clk);
        start <= 1'b0;
        vld   <= 1'b0;
        bt    <= ~bt;
        done  <= ~ab;
        abort <= ab;
        @(posedge clk);
        done  <= 1'b0;
        abort <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
endmodule // uoe_host_model

// >>> dv/tb.sv
// Self-checking bench for the OUT endpoint descriptor block.
// Assumes the host model and the bound checker sit beside the design.
`timescale 1ns/1ps
module tb
    import uoe_pkg::*;
;
    // =====================================================================
    // Bench signals
    logic        clk_sys, rstn, cyc, stb, we, ack, irq;
    logic        o_st, o_pid, o_vld, o_done, o_ab, hs_vld, ram_we;
    logic [1:0]  o_ep, hs_code, hs_c;
    logic [3:0]  sel;
    logic [7:0]  adr, o_bt, ram_wd, last_d, q;
    logic [10:0] ram_a, first_a;
    logic [31:0] wdat, rdat;
    int          err_total, samples_checked, wcnt, hs_n;

    // Free-running clock
    initial clk_sys = 1'b0;
    always #20 clk_sys = ~clk_sys;

    usb_out_endpoint_descriptor usb_out_endpoint_descriptor_inst (
        .CLK_SYS(clk_sys), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .OUT_START(o_st), .OUT_EP(o_ep), .OUT_PID_DATA1(o_pid), .OUT_BYTE_VLD(o_vld),
        .OUT_BYTE(o_bt), .OUT_DONE(o_done), .OUT_ABORT(o_ab), .HS_VLD(hs_vld),
        .HS_CODE(hs_code), .RAM_WE(ram_we), .RAM_ADDR(ram_a), .RAM_WDATA(ram_wd), .IRQ(irq));
    uoe_host_model uoe_host_model_inst (.clk(clk_sys), .start(o_st), .ep(o_ep), .pid(o_pid),
        .vld(o_vld), .bt(o_bt), .done(o_done), .abort(o_ab));

    // Monitor of buffer writes and handshakes
    always @(posedge clk_sys) begin
        if (ram_we === 1'b1) begin
            if (wcnt == 0)
                first_a <= ram_a;
            wcnt   <= wcnt + 1;
            last_d <= ram_wd;
        end
        if (hs_vld === 1'b1) begin
            hs_n <= hs_n + 1;
            hs_c <= hs_code;
        end
    end

    // =====================================================================
    // Report and compare
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("unexpected value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_num(input int g, input int e);
        samples_checked++;
        if (g != e) begin
            err_total++;
            $display("unexpected count at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Descriptor byte address of endpoint n, entry o
    function automatic logic [7:0] ra(input int n, input logic [2:0] o);
        return 8'((n * 8 + o) * 4);
    endfunction

    // Classic cycle: hold until ack is sampled, then one idle cycle
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge clk_sys);
        {cyc, stb, we} <= {2'b11, w};
        adr  <= a;
        sel  <= 4'hF;
        wdat <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 16);
        if (ack !== 1'b1) begin
            err_total++;
            finish_test();
        end
        q = rdat[7:0];
        {cyc, stb} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        chk_val(16'(q), 16'(e));
    endtask
    task automatic pkt(input int ep, input logic p, input int n, input logic ab);
        wcnt = 0;
        hs_n = 0;
        uoe_host_model_inst.send(2'(ep), p, n, ab);
    endtask

    // =====================================================================
    // Scenarios
    task automatic t_reset();
        rdchk(ra(1, OFS_CFG), 8'h00);
        rdchk(ra(1, OFS_XCNT), 8'h00);
        wr(ra(1, OFS_CFG), 8'hB3);
        rdchk(ra(1, OFS_CFG), 8'hB0);
        wr(ra(1, OFS_CFG), 8'h00);
        rdchk(8'h0C, 8'h00);
        $display("reset test done");
    endtask
    task automatic t_single();
        wr(ra(1, OFS_XBASE), 8'h12);
        wr(8'h84, 8'h01);
        wr(ra(1, OFS_CFG), 8'h84);
        pkt(1, 1'b0, 3, 1'b0);
        chk_num(wcnt, 3);
        chk_val(16'(first_a), 16'h0090);
        chk_val(16'(last_d), 16'h0058);
        chk_val(16'(hs_c), 16'(UOE_HS_ACK));
        rdchk(ra(1, OFS_XCNT), 8'h83);
        rdchk(ra(1, OFS_CFG), 8'hA4);
        rdchk(ra(1, OFS_XBASE), 8'h12);
        rdchk(8'h80, 8'h01);
        chk_val(16'(irq), 16'h0001);
        pkt(1, 1'b1, 2, 1'b0);
        chk_val(16'(hs_c), 16'(UOE_HS_NAK));
        rdchk(ra(1, OFS_XCNT), 8'h83);
        wr(8'h80, 8'h01);
        chk_val(16'(irq), 16'h0000);
        wr(8'h84, 8'h00);
        wr(ra(1, OFS_XCNT), 8'h00);
        pkt(1, 1'b1, 1, 1'b0);
        chk_val(16'(hs_c), 16'(UOE_HS_ACK));
        rdchk(ra(1, OFS_XCNT), 8'h81);
        chk_val(16'(irq), 16'h0000);
        rdchk(8'h80, 8'h01);
        wr(8'h80, 8'h01);
        $display("single buffer test done");
    endtask
    task automatic t_stall_off();
        wr(ra(1, OFS_XCNT), 8'h00);
        wr(ra(1, OFS_CFG), 8'h8C);
        pkt(1, 1'b0, 1, 1'b0);
        chk_val(16'(hs_c), 16'(UOE_HS_STALL));
        rdchk(ra(1, OFS_CFG), 8'h8C);
        wr(ra(1, OFS_CFG), 8'h84);
        pkt(1, 1'b1, 1, 1'b0);
        chk_val(16'(hs_c), 16'(UOE_HS_ACK));
        chk_num(wcnt, 0);
        rdchk(ra(1, OFS_CFG), 8'h84);
        wr(ra(1, OFS_CFG), 8'h04);
        pkt(1, 1'b0, 2, 1'b0);
        chk_num(hs_n, 0);
        chk_num(wcnt, 0);
        $display("stall and disable test done");
    endtask
    task automatic t_double_buffer_enable_abort();
        wr(ra(2, OFS_XBASE), 8'h30);
        wr(ra(2, OFS_YBASE), 8'h20);
        rdchk(ra(2, OFS_YBASE), 8'h20);
        wr(ra(2, OFS_CFG), 8'hB0);
        pkt(2, 1'b1, 64, 1'b0);
        chk_val(16'(first_a), 16'h0100);
        chk_num(wcnt, 64);
        rdchk(ra(2, OFS_YCNT), 8'hC0);
        rdchk(ra(2, OFS_XCNT), 8'h00);
        rdchk(ra(2, OFS_CFG), 8'h90);
        wr(ra(3, OFS_XBASE), 8'h40);
        wr(ra(3, OFS_CFG), 8'h84);
        pkt(3, 1'b0, 2, 1'b1);
        chk_num(hs_n, 0);
        rdchk(ra(3, OFS_XCNT), 8'h00);
        rdchk(ra(3, OFS_CFG), 8'h84);
        $display("double buffer and abort test done");
    endtask

    // Main sequence
    initial begin
        rstn = 1'b0;
        {cyc, stb, we} = 3'b000;
        sel  = 4'h0;
        adr  = 8'h00;
        wdat = 32'h0;
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset();
        t_single();
        t_stall_off();
        t_double_buffer_enable_abort();
        finish_test();
    end
endmodule // tb
